// ### logic/sosp_servo.sv
// servo output limiting, foldback, settle, tracking and trajectory generator
// Functional notes
// - current cap set as 0..100 percent
// - accumulate excess current above the cap
// - energy over limit enters foldback, clamps current
// - foldback flag at status bit 25
// - energy back to zero ends foldback
// - saturate motor command at plus/minus limit
// - add signed bias while loop enabled
// - done needs profile finished and axis settled, unless settle time is zero
// - settled flag bit 14, hardware only
// - candidate: at rest and error within window
// - candidate held settle-time servo cycles
// - settle time zero completes on profile end
// - tracking bit 13 low outside window
// - tracking loss never stops the axis
// - profile state updates, then holds after move
// - mode selects trapezoid or s-curve
// - trapezoid ramps at accel, symmetric decel
// - s-curve limits accel change to jerk
// - s-curve accel: jerk up, hold, jerk down
// - s-curve decel mirrors acceleration phase
`include "sosp_consts.svh"
module sosp_servo #(
  parameter int CYCLE_CLKS = `SOSP_CYCLE_CLKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] pid_out,
  input wire logic [15:0] cur_meas,
  input wire sosp_pkg::sosp_word_t enc_pos,
  output logic [15:0] motor_cmd,
  output logic [15:0] cur_cmd_lim
);
  import sosp_pkg::*;

  // configuration registers
  // control: loop enable, s-curve select
  logic [2:0] ctrl_q;
  // current cap and energy limit, in percent
  logic [6:0] cur_cap_q, energy_lim_q;
  // motor limit and the two position windows
  logic [15:0] motor_lim_q, settle_win_q, track_win_q;
  // constant bias added to the command
  logic signed [15:0] bias_q;
  // settle time in servo cycles
  logic [14:0] settle_time_q;
  // profile velocity, acceleration and jerk limits
  logic [31:0] vel_max_q, acc_max_q, jerk_q;
  // destination of the next move
  sosp_word_t dest_q;
  // state
  // excess current energy store
  logic [31:0] energy_q;
  // status flags
  logic fold_q, settled_q, track_q, done_q;
  // servo cycles spent as a settle candidate
  logic [14:0] settle_cnt_q;
  // clocks within the current servo cycle
  logic [15:0] tick_cnt_q;
  // profile segment
  sosp_phase_e phase_q;
  // demanded position, velocity, acceleration and signed move length
  sosp_word_t pos_q, vel_q, acc_q, dist0_q;
  // registered motor command and current command
  logic [15:0] cmd_q, cur_lim_q;

  // apb decode
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `SOSP_OFF_ACC_NOW);
  wire start_req = wr_en && (paddr == `SOSP_OFF_CTRL) && pwdata[`SOSP_CTRL_START];
  wire tick = (tick_cnt_q == 16'(CYCLE_CLKS - 1));
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // status word; bits 13, 14, 25 are hardware driven only
  wire [31:0] status_w = (32'(fold_q) << `SOSP_BIT_FOLDBACK) | (32'(settled_q) << `SOSP_BIT_SETTLED)
    | (32'(track_q) << `SOSP_BIT_TRACK) | (32'(done_q) << `SOSP_BIT_DONE)
    | (32'(phase_q != SOSP_IDLE) << `SOSP_BIT_MOVING);

  // read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        `SOSP_OFF_CTRL: prdata = {30'h0000_0000, ctrl_q[1:0]};
        `SOSP_OFF_CUR_CAP: prdata = {25'h000_0000, cur_cap_q};
        `SOSP_OFF_ENERGY_LIM: prdata = {25'h000_0000, energy_lim_q};
        `SOSP_OFF_MOTOR_LIM: prdata = {16'h0000, motor_lim_q};
        `SOSP_OFF_BIAS: prdata = {{16{bias_q[15]}}, bias_q};
        `SOSP_OFF_SETTLE_WIN: prdata = {16'h0000, settle_win_q};
        `SOSP_OFF_SETTLE_TIME: prdata = {17'h0_0000, settle_time_q};
        `SOSP_OFF_TRACK_WIN: prdata = {16'h0000, track_win_q};
        `SOSP_OFF_VEL: prdata = vel_max_q;
        `SOSP_OFF_ACC: prdata = acc_max_q;
        `SOSP_OFF_JERK: prdata = jerk_q;
        `SOSP_OFF_DEST: prdata = dest_q;
        `SOSP_OFF_STATUS: prdata = status_w;
        `SOSP_OFF_POS: prdata = pos_q;
        `SOSP_OFF_VEL_NOW: prdata = vel_q;
        `SOSP_OFF_ACC_NOW: prdata = acc_q;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // register writes; percentages above 100 saturate
  wire [6:0] pct_w = (pwdata > 32'(`SOSP_PCT_FULL)) ? `SOSP_PCT_FULL : pwdata[6:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 3'h0;
      cur_cap_q <= `SOSP_PCT_FULL;
      energy_lim_q <= `SOSP_PCT_FULL;
      motor_lim_q <= `SOSP_MLIM_RST;
      bias_q <= 16'h0000;
      settle_win_q <= 16'h0000;
      settle_time_q <= 15'h0000;
      track_win_q <= 16'hFFFF;
      vel_max_q <= 32'h0000_0000;
      acc_max_q <= 32'h0000_0000;
      jerk_q <= 32'h0000_0000;
      dest_q <= 32'h0000_0000;
    end else if (wr_en) begin
      case (paddr)
        `SOSP_OFF_CTRL: ctrl_q <= {1'b0, pwdata[1:0]};
        `SOSP_OFF_CUR_CAP: cur_cap_q <= pct_w;
        `SOSP_OFF_ENERGY_LIM: energy_lim_q <= pct_w;
        `SOSP_OFF_MOTOR_LIM: motor_lim_q <= {1'b0, pwdata[14:0]};
        `SOSP_OFF_BIAS: bias_q <= pwdata[15:0];
        `SOSP_OFF_SETTLE_WIN: settle_win_q <= pwdata[15:0];
        `SOSP_OFF_SETTLE_TIME: settle_time_q <= pwdata[14:0];
        `SOSP_OFF_TRACK_WIN: track_win_q <= pwdata[15:0];
        `SOSP_OFF_VEL: vel_max_q <= {1'b0, pwdata[30:0]};
        `SOSP_OFF_ACC: acc_max_q <= {1'b0, pwdata[30:0]};
        `SOSP_OFF_JERK: jerk_q <= (pwdata > `SOSP_JERK_MAX) ? `SOSP_JERK_MAX : pwdata;
        `SOSP_OFF_DEST: dest_q <= pwdata;
        default: ;
      endcase
    end
  end

  // servo cycle timebase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt_q <= 16'h0000;
    else tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
  end

  // foldback: current cap in measured-current units, energy limit scaled to a full-scale store
  // cap in measured-current units
  wire [22:0] cap_prod = 23'(cur_cap_q) * 23'h7FFF;
  wire [15:0] cap_cur = 16'(cap_prod / 23'd100);
  // energy limit against a full store
  wire [38:0] elim_prod = 39'(energy_lim_q) * 39'h00_FFFF_FFFF;
  wire [31:0] elim = 32'(elim_prod / 39'd100);
  // magnitude of the measured current
  wire [15:0] cur_abs = cur_meas[15] ? 16'(-cur_meas) : cur_meas;
  wire over = cur_abs > cap_cur;
  // distance of the current from the cap, either side
  wire [15:0] diff = over ? cur_abs - cap_cur : cap_cur - cur_abs;
  // store steps up by the excess, saturating at full
  wire [32:0] e_up = {1'b0, energy_q} + 33'(diff);
  wire [31:0] e_next = over ? (e_up[32] ? 32'hFFFF_FFFF : e_up[31:0])
    : ((energy_q > 32'(diff)) ? energy_q - 32'(diff) : 32'h0000_0000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      energy_q <= 32'h0000_0000;
      fold_q <= 1'b0;
    end else if (tick) begin
      energy_q <= e_next;
      if (e_next > elim) fold_q <= 1'b1;
      else if (e_next == 32'h0000_0000) fold_q <= 1'b0;
    end
  end

  // output stage: bias, saturate; commanded current capped during foldback
  wire signed [17:0] biased = ctrl_q[`SOSP_CTRL_LOOP_EN] ? 18'($signed(pid_out)) + 18'(bias_q)
    : 18'($signed(pid_out));
  wire signed [17:0] lim_p = 18'(motor_lim_q);
  wire signed [17:0] sat = (biased > lim_p) ? lim_p : (biased < -lim_p) ? -lim_p : biased;
  wire [15:0] ccap_mag = (cur_abs > cap_cur) ? cap_cur : cur_abs;
  wire [15:0] cur_l = fold_q ? (cur_meas[15] ? 16'(-ccap_mag) : ccap_mag) : cur_meas;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 16'h0000;
      cur_lim_q <= 16'h0000;
    end else begin
      cmd_q <= sat[15:0];
      cur_lim_q <= cur_l;
    end
  end
  assign motor_cmd = cmd_q;
  assign cur_cmd_lim = cur_lim_q;

  // position error against the demanded position
  wire signed [32:0] perr = 33'(pos_q) - 33'(enc_pos);
  wire [32:0] perr_abs = perr[32] ? 33'(-perr) : 33'(perr);
  wire at_rest = (phase_q == SOSP_IDLE);
  wire cand = at_rest && (perr_abs <= 33'(settle_win_q));

  // settle timer, tracking window and move done; tracking never touches motion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt_q <= 15'h0000;
      settled_q <= 1'b0;
      track_q <= 1'b1;
    end else begin
      track_q <= (perr_abs <= 33'(track_win_q));
      if (!cand) begin
        settle_cnt_q <= 15'h0000;
        settled_q <= 1'b0;
      end else if (tick) begin
        if (settle_cnt_q >= settle_time_q) settled_q <= 1'b1;
        else settle_cnt_q <= settle_cnt_q + 15'h0001;
      end
    end
  end
  wire zero_time = (settle_time_q == 15'h0000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) done_q <= 1'b0;
    else if (start_req) done_q <= 1'b0;
    else if (at_rest && (zero_time || settled_q)) done_q <= 1'b1;
  end

  // trajectory generator; one step per servo cycle
  wire scurve = ctrl_q[`SOSP_CTRL_SCURVE];
  // distance left, signed, then as a magnitude along the move
  wire signed [31:0] remain = dest_q - pos_q;
  wire dir_neg = dist0_q[31];
  wire [31:0] rem_abs = dir_neg ? 32'(-remain) : remain;
  // speed and acceleration magnitudes
  wire [31:0] vabs = dir_neg ? 32'(-vel_q) : vel_q;
  wire [31:0] aabs = acc_q[31] ? 32'(-acc_q) : acc_q;
  // stopping distance at the set deceleration
  wire [63:0] brake = (64'(vabs) * 64'(vabs)) / (64'(acc_max_q) * 64'd2 + 64'd1);
  wire need_brake = (64'(rem_abs) <= brake + 64'(vabs));
  // acceleration one jerk step up or down, clamped
  wire [31:0] a_up = (aabs + jerk_q > acc_max_q) ? acc_max_q : aabs + jerk_q;
  wire [31:0] a_dn = (aabs > jerk_q) ? aabs - jerk_q : 32'h0000_0000;
  // acceleration stored with the sign of travel; braking opposes it
  wire [31:0] fwd_up = dir_neg ? 32'(-a_up) : a_up;
  wire [31:0] fwd_dn = dir_neg ? 32'(-a_dn) : a_dn;
  wire [31:0] brk_up = dir_neg ? a_up : 32'(-a_up);
  wire [31:0] brk_dn = dir_neg ? a_dn : 32'(-a_dn);
  // rate used for the speed step: jerk-shaped or the set acceleration
  wire [31:0] a_use = scurve ? aabs : acc_max_q;
  wire [31:0] v_up = (vabs + a_use > vel_max_q) ? vel_max_q : vabs + a_use;
  wire [31:0] v_dn = (vabs > a_use) ? vabs - a_use : 32'h0000_0001;
  wire [31:0] v_sel = need_brake ? v_dn : v_up;
  wire [31:0] step = (v_sel > rem_abs) ? rem_abs : v_sel;
  wire arrive = (rem_abs == 32'h0000_0000) || (step == rem_abs);
  wire [31:0] vgap = vel_max_q - vabs;
  wire jdn_start = (64'(aabs) * 64'(aabs) / (64'(jerk_q) * 64'd2 + 64'd1)) >= 64'(vgap);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= SOSP_IDLE;
      pos_q <= 32'h0000_0000;
      vel_q <= 32'h0000_0000;
      acc_q <= 32'h0000_0000;
      dist0_q <= 32'h0000_0000;
    end else if (start_req && at_rest) begin
      phase_q <= SOSP_JUP; // from zero velocity
      vel_q <= 32'h0000_0000;
      acc_q <= 32'h0000_0000;
      dist0_q <= dest_q - pos_q;
    end else if (tick && !at_rest) begin
      pos_q <= dir_neg ? pos_q - step : pos_q + step;
      vel_q <= dir_neg ? 32'(-step) : step;
      acc_q <= dir_neg ? 32'(-(v_sel - vabs)) : v_sel - vabs;
      if (arrive) begin
        phase_q <= SOSP_IDLE; // values hold until next start
        vel_q <= 32'h0000_0000;
        acc_q <= 32'h0000_0000;
      end else if (scurve) begin
        case (phase_q)
          SOSP_JUP: begin
            acc_q <= fwd_up;
            if (need_brake) phase_q <= SOSP_DJUP;
            else if (jdn_start) phase_q <= SOSP_JDN;
            else if (a_up == acc_max_q) phase_q <= SOSP_AHOLD;
          end
          SOSP_AHOLD: begin
            if (need_brake) phase_q <= SOSP_DJUP;
            else if (jdn_start) phase_q <= SOSP_JDN;
          end
          SOSP_JDN: begin
            acc_q <= fwd_dn;
            if (need_brake) phase_q <= SOSP_DJUP;
            else if (a_dn == 32'h0000_0000) phase_q <= SOSP_CRUISE;
          end
          SOSP_CRUISE: if (need_brake) phase_q <= SOSP_DJUP;
          SOSP_DJUP: begin
            acc_q <= brk_up;
            if (a_up == acc_max_q) phase_q <= SOSP_DHOLD;
          end
          SOSP_DHOLD: if (jdn_start) phase_q <= SOSP_DJDN;
          SOSP_DJDN: acc_q <= brk_dn;
          default: phase_q <= SOSP_IDLE;
        endcase
      end else begin
        phase_q <= need_brake ? SOSP_DHOLD : SOSP_CRUISE;
      end
    end
  end

  // assertions; all on the bus clock, quiet while reset is held
  // energy over the limit raises foldback at the next clock
  property p_fold_set; @(posedge pclk) disable iff (!presetn)
    (tick && e_next > elim) |=> fold_q; endproperty
  a_fold_set: assert property (p_fold_set) else $error("foldback not entered");
  // status readback carries the foldback flag
  property p_fold_flag; @(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `SOSP_OFF_STATUS) |-> prdata[`SOSP_BIT_FOLDBACK] == fold_q; endproperty
  a_fold_flag: assert property (p_fold_flag) else $error("foldback bit wrong");
  // drained store ends foldback
  property p_fold_clr; @(posedge pclk) disable iff (!presetn)
    (fold_q && tick && e_next == 32'h0000_0000) |=> !fold_q; endproperty
  a_fold_clr: assert property (p_fold_clr) else $error("foldback not cleared");
  // in foldback a positive overcurrent is cut to the cap
  property p_cap_fold; @(posedge pclk) disable iff (!presetn)
    (fold_q && !cur_meas[15] && cur_abs > cap_cur) |=> cur_cmd_lim == $past(cap_cur); endproperty
  a_cap_fold: assert property (p_cap_fold) else $error("current not capped in foldback");
  // command stays within plus and minus the limit while the limit is steady
  property p_sat; @(posedge pclk) disable iff (!presetn)
    $stable(motor_lim_q) |-> ($signed(motor_cmd) <= $signed(motor_lim_q))
      && ($signed(motor_cmd) >= -$signed(motor_lim_q)); endproperty
  a_sat: assert property (p_sat) else $error("motor command outside limit");
  // tracking bit low outside the window
  property p_track; @(posedge pclk) disable iff (!presetn)
    (perr_abs > 33'(track_win_q)) |=> !track_q; endproperty
  a_track: assert property (p_track) else $error("tracking bit stayed high");
  // and high again inside it
  property p_track_back; @(posedge pclk) disable iff (!presetn)
    (perr_abs <= 33'(track_win_q)) |=> track_q; endproperty
  a_track_back: assert property (p_track_back) else $error("tracking bit stayed low");
  // settled only at rest
  property p_settle_rest; @(posedge pclk) disable iff (!presetn)
    settled_q |-> $past(at_rest); endproperty
  a_settle_rest: assert property (p_settle_rest) else $error("settled while moving");
  // settled rises only after the full settle count
  property p_settle_time; @(posedge pclk) disable iff (!presetn)
    $rose(settled_q) |-> $past(tick) && $past(cand) && $past(settle_cnt_q >= settle_time_q); endproperty
  a_settle_time: assert property (p_settle_time) else $error("settled before settle time");
  // done only after profile end and settle, or with zero settle time
  property p_done; @(posedge pclk) disable iff (!presetn)
    $rose(done_q) |-> $past(at_rest) && ($past(zero_time) || $past(settled_q)); endproperty
  a_done: assert property (p_done) else $error("done without settle");
  // demanded position holds at rest
  property p_hold; @(posedge pclk) disable iff (!presetn)
    (at_rest && !start_req) |=> $stable(pos_q); endproperty
  a_hold: assert property (p_hold) else $error("position moved at rest");
  // shortfall never drives the store below zero
  property p_energy_floor; @(posedge pclk) disable iff (!presetn)
    (tick && !over && energy_q <= 32'(diff)) |=> energy_q == 32'h0000_0000; endproperty
  a_energy_floor: assert property (p_energy_floor) else $error("energy floor wrong");
  // s-curve acceleration grows by at most the jerk per cycle in the jerk-up phase
  property p_jerk; @(posedge pclk) disable iff (!presetn)
    (tick && scurve && phase_q == SOSP_JUP && !arrive) |=> aabs <= $past(aabs) + $past(jerk_q); endproperty
  a_jerk: assert property (p_jerk) else $error("acceleration step above jerk");
  // main scenarios reached
  c_fold: cover property (@(posedge pclk) $rose(fold_q));
  c_settled: cover property (@(posedge pclk) $rose(settled_q));
  c_done: cover property (@(posedge pclk) $rose(done_q));
  c_scurve: cover property (@(posedge pclk) phase_q == SOSP_DJDN);
endmodule : sosp_servo

// ### pkg/sosp_consts.svh
// register offsets, field positions, reset values and timing counts for the servo settle block
`ifndef SOSP_CONSTS_SVH
`define SOSP_CONSTS_SVH
`define SOSP_OFF_CTRL 12'h000
`define SOSP_OFF_CUR_CAP 12'h004
`define SOSP_OFF_ENERGY_LIM 12'h008
`define SOSP_OFF_MOTOR_LIM 12'h00C
`define SOSP_OFF_BIAS 12'h010
`define SOSP_OFF_SETTLE_WIN 12'h014
`define SOSP_OFF_SETTLE_TIME 12'h018
`define SOSP_OFF_TRACK_WIN 12'h01C
`define SOSP_OFF_VEL 12'h020
`define SOSP_OFF_ACC 12'h024
`define SOSP_OFF_JERK 12'h028
`define SOSP_OFF_DEST 12'h02C
`define SOSP_OFF_STATUS 12'h030
`define SOSP_OFF_POS 12'h034
`define SOSP_OFF_VEL_NOW 12'h038
`define SOSP_OFF_ACC_NOW 12'h03C
`define SOSP_BIT_TRACK 13
`define SOSP_BIT_SETTLED 14
`define SOSP_BIT_FOLDBACK 25
`define SOSP_BIT_DONE 0
`define SOSP_BIT_MOVING 1
`define SOSP_CTRL_LOOP_EN 0
`define SOSP_CTRL_SCURVE 1
`define SOSP_CTRL_START 2
`define SOSP_PCT_FULL 7'd100
`define SOSP_MLIM_RST 16'h7FFF
`define SOSP_JERK_MAX 32'h02C6_8AFB
`define SOSP_CYCLE_NS 102400
`define SOSP_CLK_NS 10
`define SOSP_CYCLE_CLKS (`SOSP_CYCLE_NS / `SOSP_CLK_NS)
`endif

// ### pkg/sosp_pkg.sv
// types for the servo settle and profile block
package sosp_pkg;
  typedef enum logic [2:0] {
    SOSP_IDLE, SOSP_JUP, SOSP_AHOLD, SOSP_JDN, SOSP_CRUISE, SOSP_DJUP, SOSP_DHOLD, SOSP_DJDN
  } sosp_phase_e;
  typedef logic signed [31:0] sosp_word_t;
endpackage : sosp_pkg

// ### dv/sosp_drive_model.sv
// drive stage and encoder stand-in for the servo settle bench
module sosp_drive_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire sosp_pkg::sosp_word_t tgt_pos,
  input wire logic [15:0] cur_level,
  output logic [15:0] cur_meas,
  output sosp_pkg::sosp_word_t enc_pos
);
  timeunit 1ns;
  timeprecision 1ps;
  import sosp_pkg::*;
  // current sensor follows the level; encoder jumps, or creeps a count per clock when slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_meas <= '0;
      enc_pos <= '0;
    end else begin
      cur_meas <= cur_level;
      if (!slow) begin
        enc_pos <= tgt_pos;
      end else if (enc_pos < tgt_pos) begin
        enc_pos <= enc_pos + 1;
      end else if (enc_pos > tgt_pos) begin
        enc_pos <= enc_pos - 1;
      end
    end
  end
endmodule : sosp_drive_model

// ### dv/tb_servo_output_settle_profile.sv
// self-checking bench for the servo settle and profile block
`include "sosp_consts.svh"
module tb_servo_output_settle_profile;
  timeunit 1ns;
  timeprecision 1ps;
  import sosp_pkg::*;
  localparam int CYC = 16; // shortened servo cycle in clocks
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pid_out, cur_meas, motor_cmd, cur_cmd_lim, cur_level;
  sosp_word_t enc_pos, tgt_pos, mv, ma, ms;
  int num_errors, comparisons;
  sosp_servo #(.CYCLE_CLKS(CYC)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pid_out(pid_out), .cur_meas(cur_meas), .enc_pos(enc_pos), .motor_cmd(motor_cmd), .cur_cmd_lim(cur_cmd_lim));
  sosp_drive_model u_drv (.pclk(pclk), .presetn(presetn), .slow(slow), .tgt_pos(tgt_pos),
    .cur_level(cur_level), .cur_meas(cur_meas), .enc_pos(enc_pos));
  // free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // verdict and end of run
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  // compare and count
  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // one apb transfer, held until pready is sampled high
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // register read against an expected word
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, '0);
    check($sformatf("reg %h", a), exp, rd);
  endtask : rd_chk
  // poll one status bit, bounded by a read count
  task st_wait(input int b, input logic v, input int n);
    xfer(1'b0, `SOSP_OFF_STATUS, '0);
    for (int i = 1; i < n && rd[b] !== v; i++) xfer(1'b0, `SOSP_OFF_STATUS, '0);
    check($sformatf("status bit %0d", b), {31'h0, v}, {31'h0, rd[b]});
  endtask : st_wait
  // drive the filter result and look at the registered command
  task cmd_chk(input logic [15:0] p, input logic [15:0] e);
    pid_out <= p;
    repeat (3) @(posedge pclk);
    check("motor_cmd", {16'h0, e}, {16'h0, motor_cmd});
  endtask : cmd_chk
  function automatic sosp_word_t absv(input sosp_word_t x);
    return (x < 0) ? -x : x;
  endfunction : absv
  // start a move and record peak velocity, acceleration and accel step
  task move(input logic [31:0] ctrl, input logic [31:0] dest);
    sosp_word_t a, pa;
    xfer(1'b1, `SOSP_OFF_DEST, dest);
    xfer(1'b1, `SOSP_OFF_CTRL, ctrl);
    st_wait(`SOSP_BIT_MOVING, 1'b1, 40);
    mv = 0;
    ma = 0;
    ms = 0;
    pa = 0;
    for (int i = 0; i < 4000 && rd[`SOSP_BIT_MOVING] === 1'b1; i++) begin
      xfer(1'b0, `SOSP_OFF_VEL_NOW, '0);
      if (sosp_word_t'(rd) > mv) mv = rd;
      xfer(1'b0, `SOSP_OFF_ACC_NOW, '0);
      a = rd;
      if (absv(a) > ma) ma = absv(a);
      if (absv(a - pa) > ms) ms = absv(a - pa);
      pa = a;
      xfer(1'b0, `SOSP_OFF_STATUS, '0);
    end
  endtask : move
  // watchdog: whole run is some 3k clocks
  initial begin
    #900_000;
    num_errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, slow} = '0;
    {paddr, pwdata, pid_out, cur_level, tgt_pos} = '0;
    num_errors = 0;
    comparisons = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`SOSP_OFF_MOTOR_LIM, 32'h0000_7fff);
    rd_chk(`SOSP_OFF_BIAS, 32'h0000_0000);
    check("pready", 32'h0000_0001, {31'h0, pready});
    st_wait(`SOSP_BIT_TRACK, 1'b1, 1);
    xfer(1'b0, 12'h0f0, '0);
    check("unmapped err", 32'h0000_0001, {31'h0, er});
    // saturation and bias
    xfer(1'b1, `SOSP_OFF_MOTOR_LIM, 32'h0000_7530);
    xfer(1'b1, `SOSP_OFF_CTRL, 32'h0000_0001);
    cmd_chk(16'h7d00, 16'h7530);
    cmd_chk(16'h8300, 16'h8ad0);
    xfer(1'b1, `SOSP_OFF_BIAS, 32'hffff_ff9c);
    cmd_chk(16'h03e8, 16'h0384);
    cmd_chk(16'h7562, 16'h74fe);
    xfer(1'b1, `SOSP_OFF_CTRL, 32'h0000_0000);
    cmd_chk(16'h03e8, 16'h03e8);
    // tracking window, boundary inclusive
    xfer(1'b1, `SOSP_OFF_TRACK_WIN, 32'h0000_000a);
    tgt_pos <= 20;
    st_wait(`SOSP_BIT_TRACK, 1'b0, 4);
    tgt_pos <= 10;
    st_wait(`SOSP_BIT_TRACK, 1'b1, 4);
    tgt_pos <= 20;
    st_wait(`SOSP_BIT_TRACK, 1'b0, 4);
    // trapezoid with zero settle time, axis left far off
    xfer(1'b1, `SOSP_OFF_SETTLE_TIME, 32'h0000_0000);
    xfer(1'b1, `SOSP_OFF_VEL, 32'h0000_0004);
    xfer(1'b1, `SOSP_OFF_ACC, 32'h0000_0001);
    move(32'h0000_0005, 32'h0000_0064);
    check("peak vel", 32'h0000_0004, mv);
    check("peak acc", 32'h0000_0001, ma);
    st_wait(`SOSP_BIT_DONE, 1'b1, 4);
    st_wait(`SOSP_BIT_TRACK, 1'b0, 1);
    rd_chk(`SOSP_OFF_POS, 32'h0000_0064);
    repeat (3 * CYC) @(posedge pclk);
    rd_chk(`SOSP_OFF_POS, 32'h0000_0064);
    rd_chk(`SOSP_OFF_VEL_NOW, 32'h0000_0000);
    // settle needs rest, window and time
    xfer(1'b1, `SOSP_OFF_SETTLE_WIN, 32'h0000_0005);
    xfer(1'b1, `SOSP_OFF_SETTLE_TIME, 32'h0000_0003);
    move(32'h0000_0005, 32'h0000_0096);
    repeat (5 * CYC) @(posedge pclk);
    st_wait(`SOSP_BIT_DONE, 1'b0, 1);
    st_wait(`SOSP_BIT_SETTLED, 1'b0, 1);
    slow <= 1'b1;
    tgt_pos <= 145;
    for (int i = 0; i < 400 && enc_pos !== 145; i++) @(posedge pclk);
    st_wait(`SOSP_BIT_SETTLED, 1'b0, 1);
    st_wait(`SOSP_BIT_SETTLED, 1'b1, 60);
    st_wait(`SOSP_BIT_DONE, 1'b1, 1);
    xfer(1'b1, `SOSP_OFF_STATUS, '0);
    st_wait(`SOSP_BIT_SETTLED, 1'b1, 1);
    // s-curve move
    xfer(1'b1, `SOSP_OFF_SETTLE_TIME, 32'h0000_0000);
    xfer(1'b1, `SOSP_OFF_JERK, 32'h0000_0001);
    xfer(1'b1, `SOSP_OFF_ACC, 32'h0000_0002);
    move(32'h0000_0007, 32'h0000_0190);
    check("accel step", 32'h0000_0001, ms);
    check("peak acc", 32'h0000_0002, ma);
    check("peak vel", 32'h0000_0004, mv);
    rd_chk(`SOSP_OFF_POS, 32'h0000_0190);
    // current cap and foldback
    xfer(1'b1, `SOSP_OFF_CUR_CAP, 32'h0000_0096);
    rd_chk(`SOSP_OFF_CUR_CAP, 32'h0000_0064);
    xfer(1'b1, `SOSP_OFF_CUR_CAP, 32'h0000_0032);
    xfer(1'b1, `SOSP_OFF_ENERGY_LIM, 32'h0000_0000);
    cur_level <= 16'h7d00;
    st_wait(`SOSP_BIT_FOLDBACK, 1'b1, 20);
    repeat (2) @(posedge pclk);
    check("cur_cmd_lim", 32'h0000_3fff, {16'h0, cur_cmd_lim});
    cur_level <= 16'h03e8;
    st_wait(`SOSP_BIT_FOLDBACK, 1'b0, 200);
    repeat (2) @(posedge pclk);
    check("cur_cmd_lim", 32'h0000_03e8, {16'h0, cur_cmd_lim});
    repeat (20 * CYC) @(posedge pclk);
    cur_level <= 16'h4e20;
    st_wait(`SOSP_BIT_FOLDBACK, 1'b1, 12);
    report_and_stop();
  end
endmodule : tb_servo_output_settle_profile
